// File: core/lds_params.svh
// Numeric constants of the serial write port and blink timer.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LDS_PARAMS_SVH
`define LDS_PARAMS_SVH

// Command word layout: address in the upper byte, data in the lower
`define LDS_WORD_BITS 16
`define LDS_ADDR_MSB 15
`define LDS_ADDR_LSB 8
`define LDS_DATA_MSB 7
`define LDS_DATA_LSB 0

// Command addresses decoded locally
`define LDS_CFG_ADDR 8'h04
`define LDS_SEG_ADDR 8'h01

// Configuration byte field positions
`define LDS_CFG_RUN_BIT 0
`define LDS_CFG_FAST_BIT 2
`define LDS_CFG_BLINK_EN_BIT 3
`define LDS_CFG_BLINK_RST_BIT 4

// Reset values
`define LDS_SHUTDOWN_RST 1'h1
`define LDS_BLINK_FAST_RST 1'h0
`define LDS_BLINK_EN_RST 1'h0
`define LDS_SEG_PAT_RST 9'h000
`define LDS_PHASE_RST 1'h1

// Clock rates in Hz, blink periods in ms
`define LDS_SYS_HZ 20000000
`define LDS_REF_OSC_HZ 4000000
`define LDS_SCAN_HZ 625
`define LDS_DIGITS 8
`define LDS_PINS 9
`define LDS_SLOW_BLINK_MS 1000
`define LDS_FAST_BLINK_MS 500
`define LDS_FIFO_DEPTH 8

`endif

// File: core/lds_pkg.sv
// Shared types of the serial write port and display scan.
// Assumes lds_params.svh is on the include path.
`include "lds_params.svh"

package lds_pkg;

	typedef logic [`LDS_WORD_BITS-1:0] lds_word_t;

	// How one segment/digit pin is driven in a scan slot
	typedef enum logic [1:0] {
		LDS_PIN_OFF = 2'h0,
		LDS_PIN_SRC = 2'h1,
		LDS_PIN_SINK = 2'h2
	} lds_pin_drv_t;

endpackage : lds_pkg

// File: core/lds_fifo.sv
// Word FIFO with valid/ready on both sides and a registered read port.
// Assumes one clock; DEPTH must be a power of two.
`timescale 1ns/100ps

module lds_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
		logic [WIDTH-1:0] dout;
		logic dout_vld;
	} lds_fifo_st_t;

	lds_fifo_st_t st_ff;
	lds_fifo_st_t nxt_st;
	logic [AW:0] fill;
	logic empty;

	// Occupancy of the array, not counting the output register
	assign fill = st_ff.wr_ptr - st_ff.rd_ptr;
	assign empty = (fill == '0);
	assign in_ready = (fill != (AW+1)'(DEPTH));
	assign out_valid = st_ff.dout_vld;
	assign out_data = st_ff.dout;

	// Write, then refill the output register whenever it frees up
	always_comb begin
		nxt_st = st_ff;
		if (in_valid && in_ready) begin
			nxt_st.mem[st_ff.wr_ptr[AW-1:0]] = in_data;
			nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
		end
		if (out_ready) begin
			nxt_st.dout_vld = 1'b0;
		end
		// A word written this cycle is seen one cycle later
		if ((!st_ff.dout_vld || out_ready) && !empty) begin
			nxt_st.dout = st_ff.mem[st_ff.rd_ptr[AW-1:0]];
			nxt_st.dout_vld = 1'b1;
			nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule : lds_fifo

// File: core/lds_serial_blink.sv
// Serial command port, command queue, blink timer and pin scan.
// Assumes ser_clk comes from the host and stops between frames.
//
// How it works
// - Shift din into 16-bit register on rising clock
// - No shifting while chip select is high
// - Chip select rise latches last 16 bits
// - Slow blink full period one second
// - Fast blink full period half second
// - Blink on and off phases exactly equal; the first half period after a timing reset may be up to a tick short
// - Pins not driving are released, high impedance
// - Word is MSB first, address high, data low
// - Odd-length frames latch the last sixteen bits
// - No readback path exists at all
`timescale 1ns/100ps
`include "lds_params.svh"

module lds_serial_blink #(
	parameter int unsigned SLOW_HALF_TICKS =
		`LDS_REF_OSC_HZ / 1000 * `LDS_SLOW_BLINK_MS / 2,
	parameter int unsigned FAST_HALF_TICKS =
		`LDS_REF_OSC_HZ / 1000 * `LDS_FAST_BLINK_MS / 2,
	parameter int FIFO_DEPTH = `LDS_FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ser_clk,
	input wire logic ser_cs_n,
	input wire logic ser_din,
	input wire logic multiplex_clock_pin,
	input wire logic mux_ext_sel,
	input wire logic cmd_ready,
	input wire logic overrun_clr,
	output logic cmd_valid,
	output logic [7:0] cmd_addr,
	output logic [7:0] cmd_data,
	output logic blink_phase,
	output logic shutdown,
	output logic overrun,
	output logic [`LDS_PINS-1:0] segment_digit_outputs,
	output logic [`LDS_PINS-1:0] segment_digit_oe_n
);

	// Trade-off: a fixed divider stands in for the RC oscillator,
	// so the multiplex rate tracks clk_sys rather than a set resistor
	// Internal oscillator stand-in: sys clocks per multiplex tick
	localparam logic [7:0] OSC_DIV_M1 =
		8'(`LDS_SYS_HZ / `LDS_REF_OSC_HZ - 1);
	// Multiplex ticks per digit slot
	localparam logic [11:0] SCAN_TICKS_M1 =
		12'(`LDS_REF_OSC_HZ / (`LDS_SCAN_HZ * `LDS_DIGITS) - 1);
	localparam logic [23:0] SLOW_HALF_M1 = 24'(SLOW_HALF_TICKS - 1);
	localparam logic [23:0] FAST_HALF_M1 = 24'(FAST_HALF_TICKS - 1);
	localparam logic [2:0] LAST_DIGIT = 3'(`LDS_DIGITS - 1);

	// Link side state: only the shift register
	typedef struct packed {
		lds_pkg::lds_word_t shreg;
	} lds_lnk_st_t;

	// System side state
	typedef struct packed {
		logic cs_meta;
		logic cs_sync;
		logic cs_prev;
		logic mux_meta;
		logic mux_sync;
		logic mux_prev;
		logic ext_meta;
		logic ext_sync;
		logic [7:0] osc_div;
		logic pend;
		lds_pkg::lds_word_t pend_word;
		logic overrun;
		logic cmd_vld;
		lds_pkg::lds_word_t cmd_word;
		logic shutdown;
		logic blink_fast;
		logic blink_en;
		logic [`LDS_PINS-1:0] seg_pat;
		logic [2:0] digit;
		logic [11:0] scan_cnt;
		logic [23:0] blink_cnt;
		logic blink_phase;
		logic [`LDS_PINS-1:0] pin_out;
		logic [`LDS_PINS-1:0] pin_oe_n;
	} lds_sys_st_t;

	lds_lnk_st_t lnk_ff;
	lds_lnk_st_t nxt_lnk;
	lds_sys_st_t sys_ff;
	lds_sys_st_t nxt_sys;

	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	lds_pkg::lds_word_t fifo_out_data;
	logic cs_rise;
	logic mux_tick;

	// Drive of one pin in the current slot; unlit pins are released
	function automatic lds_pkg::lds_pin_drv_t pin_drive(
		input int pin,
		input logic [2:0] digit,
		input logic seg_on,
		input logic off
	);
		lds_pkg::lds_pin_drv_t drv;
		drv = lds_pkg::LDS_PIN_OFF;
		if (!off) begin
			if (pin < `LDS_DIGITS && 3'(pin) == digit) begin
				drv = lds_pkg::LDS_PIN_SINK;
			end else if (seg_on) begin
				drv = lds_pkg::LDS_PIN_SRC;
			end
		end
		return drv;
	endfunction : pin_drive

	// Link side: shift MSB first while selected; the previous contents
	// slide out, so any frame length leaves the last 16 bits
	always_comb begin
		nxt_lnk = lnk_ff;
		if (!ser_cs_n) begin
			nxt_lnk.shreg = {lnk_ff.shreg[`LDS_WORD_BITS-2:0], ser_din};
		end
	end

	// Reset clears the shift register, so a short first frame
	// after reset latches zeros in its leading bits
	always_ff @(posedge ser_clk or negedge rst_n) begin
		if (!rst_n) begin
			lnk_ff <= '0;
		end else begin
			lnk_ff <= nxt_lnk;
		end
	end

	// Select rise seen after two flops; link clock is stopped by then
	assign cs_rise = sys_ff.cs_sync && !sys_ff.cs_prev;
	// Multiplex tick from the pin edge or the internal divider
	assign mux_tick = sys_ff.ext_sync ?
		(sys_ff.mux_sync && !sys_ff.mux_prev) :
		(sys_ff.osc_div == '0);
	// Drain stalls while the command slot is still occupied
	assign fifo_out_ready = !sys_ff.cmd_vld || cmd_ready;

	always_comb begin
		nxt_sys = sys_ff;
		// Synchronisers for the pins
		nxt_sys.cs_meta = ser_cs_n;
		nxt_sys.cs_sync = sys_ff.cs_meta;
		nxt_sys.cs_prev = sys_ff.cs_sync;
		nxt_sys.mux_meta = multiplex_clock_pin;
		nxt_sys.mux_sync = sys_ff.mux_meta;
		nxt_sys.mux_prev = sys_ff.mux_sync;
		nxt_sys.ext_meta = mux_ext_sel;
		nxt_sys.ext_sync = sys_ff.ext_meta;

		// Free-running divider, halted in shutdown to save power
		if (sys_ff.shutdown || sys_ff.osc_div == '0) begin
			nxt_sys.osc_div = OSC_DIV_M1;
		end else begin
			nxt_sys.osc_div = sys_ff.osc_div - 8'h01;
		end

		// Capture slot feeding the queue
		if (sys_ff.pend && fifo_in_ready) begin
			nxt_sys.pend = 1'b0;
		end
		if (overrun_clr) begin
			nxt_sys.overrun = 1'b0;
		end
		// Set wins over a same-cycle clear, so no drop goes unseen
		if (cs_rise) begin
			if (nxt_sys.pend) begin
				// Queue and slot both full: the new word is lost
				nxt_sys.overrun = 1'b1;
			end else begin
				nxt_sys.pend = 1'b1;
				nxt_sys.pend_word = lnk_ff.shreg;
			end
		end

		// Command slot and local decode of the latched word
		if (cmd_ready) begin
			nxt_sys.cmd_vld = 1'b0;
		end
		if (fifo_out_valid && fifo_out_ready) begin
			nxt_sys.cmd_vld = 1'b1;
			nxt_sys.cmd_word = fifo_out_data;
			if (fifo_out_data[`LDS_ADDR_MSB:`LDS_ADDR_LSB] ==
					`LDS_CFG_ADDR) begin
				nxt_sys.shutdown =
					!fifo_out_data[`LDS_CFG_RUN_BIT];
				nxt_sys.blink_fast =
					fifo_out_data[`LDS_CFG_FAST_BIT];
				nxt_sys.blink_en =
					fifo_out_data[`LDS_CFG_BLINK_EN_BIT];
			end
			if (fifo_out_data[`LDS_ADDR_MSB:`LDS_ADDR_LSB] ==
					`LDS_SEG_ADDR) begin
				nxt_sys.seg_pat = {1'b0,
					fifo_out_data[`LDS_DATA_MSB:`LDS_DATA_LSB]};
			end
		end

		// Digit scan advances one slot per SCAN_TICKS ticks
		if (mux_tick && !sys_ff.shutdown) begin
			if (sys_ff.scan_cnt == SCAN_TICKS_M1) begin
				nxt_sys.scan_cnt = '0;
				nxt_sys.digit = (sys_ff.digit == LAST_DIGIT) ?
					3'h0 : sys_ff.digit + 3'h1;
			end else begin
				nxt_sys.scan_cnt = sys_ff.scan_cnt + 12'h001;
			end
		end

		// Blink timer: equal half periods give an exact 50 % duty
		// Limitation: the divider is not restarted by a timing reset,
		// so the first half period after it may be up to a tick short
		if (mux_tick && !sys_ff.shutdown) begin
			if (sys_ff.blink_cnt >= (sys_ff.blink_fast ?
					FAST_HALF_M1 : SLOW_HALF_M1)) begin
				nxt_sys.blink_cnt = '0;
				nxt_sys.blink_phase = !sys_ff.blink_phase;
			end else begin
				nxt_sys.blink_cnt = sys_ff.blink_cnt + 24'h000001;
			end
		end
		// Timing reset restarts the on phase, for syncing drivers
		if (fifo_out_valid && fifo_out_ready &&
				fifo_out_data[`LDS_ADDR_MSB:`LDS_ADDR_LSB] ==
				`LDS_CFG_ADDR &&
				fifo_out_data[`LDS_CFG_BLINK_RST_BIT]) begin
			nxt_sys.blink_cnt = '0;
			nxt_sys.blink_phase = `LDS_PHASE_RST;
		end

		// Pin drive for the current slot
		for (int p = 0; p < `LDS_PINS; p++) begin
			case (pin_drive(p, sys_ff.digit,
					sys_ff.seg_pat[p] &&
					(!sys_ff.blink_en || sys_ff.blink_phase),
					sys_ff.shutdown))
				lds_pkg::LDS_PIN_SINK: begin
					nxt_sys.pin_out[p] = 1'b0;
					nxt_sys.pin_oe_n[p] = 1'b0;
				end
				lds_pkg::LDS_PIN_SRC: begin
					nxt_sys.pin_out[p] = 1'b1;
					nxt_sys.pin_oe_n[p] = 1'b0;
				end
				default: begin
					nxt_sys.pin_out[p] = 1'b0;
					nxt_sys.pin_oe_n[p] = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sys_ff <= '0;
			sys_ff.cs_meta <= 1'b1;
			sys_ff.cs_sync <= 1'b1;
			sys_ff.cs_prev <= 1'b1;
			sys_ff.shutdown <= `LDS_SHUTDOWN_RST;
			sys_ff.blink_fast <= `LDS_BLINK_FAST_RST;
			sys_ff.blink_en <= `LDS_BLINK_EN_RST;
			sys_ff.seg_pat <= `LDS_SEG_PAT_RST;
			sys_ff.blink_phase <= `LDS_PHASE_RST;
			sys_ff.pin_oe_n <= '1;
		end else begin
			sys_ff <= nxt_sys;
		end
	end

	// Queue between the capture slot and the command slot
	lds_fifo #(
		.WIDTH(`LDS_WORD_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(sys_ff.pend),
		.in_ready(fifo_in_ready),
		.in_data(sys_ff.pend_word),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// All outputs straight from flops; nothing is ever read back
	assign cmd_valid = sys_ff.cmd_vld;
	assign cmd_addr = sys_ff.cmd_word[`LDS_ADDR_MSB:`LDS_ADDR_LSB];
	assign cmd_data = sys_ff.cmd_word[`LDS_DATA_MSB:`LDS_DATA_LSB];
	assign blink_phase = sys_ff.blink_phase;
	assign shutdown = sys_ff.shutdown;
	assign overrun = sys_ff.overrun;
	assign segment_digit_outputs = sys_ff.pin_out;
	assign segment_digit_oe_n = sys_ff.pin_oe_n;

endmodule : lds_serial_blink

// File: verification/lds_serial_blink_asserts.sv
// Checker for the serial port, command queue and pin outputs.
// Assumes a bind onto lds_serial_blink; sees its ports only.
`timescale 1ns/100ps
`include "lds_params.svh"

module lds_serial_blink_asserts (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ser_cs_n,
	input wire logic cmd_ready,
	input wire logic overrun_clr,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	input wire logic blink_phase,
	input wire logic shutdown,
	input wire logic overrun,
	input wire logic [`LDS_PINS-1:0] segment_digit_outputs,
	input wire logic [`LDS_PINS-1:0] segment_digit_oe_n
);
	// One domain here, so one clock and reset for all
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Pins pulled low: only the scanned digit may sink
	wire logic [7:0] sink = ~segment_digit_oe_n[7:0] &
		~segment_digit_outputs[7:0];

	chk_cmd_hold: assert property (
		cmd_valid && !cmd_ready |=> cmd_valid && $stable({cmd_addr, cmd_data}))
		else $error("cmd word changed before taken");
	chk_cmd_latency: assert property (
		$rose(ser_cs_n) && cmd_ready && !cmd_valid |-> ##[2:12] cmd_valid)
		else $error("no cmd after select rise");
	chk_overrun_sticky: assert property (
		overrun && !overrun_clr |=> overrun) else $error("overrun lost");
	chk_shut_release: assert property (
		shutdown |=> &segment_digit_oe_n) else $error("pin driven in shutdown");
	chk_run_digit: assert property (
		!shutdown ##1 !shutdown |-> $onehot(sink))
		else $error("no single digit sink");
	chk_one_sink: assert property (
		$onehot0(sink)) else $error("two digit sinks");
	chk_blink_halt: assert property (
		shutdown ##1 shutdown |-> $stable(blink_phase))
		else $error("blink ran in shutdown");
	chk_reset_vals: assert property (
		$rose(rst_n) |-> shutdown && blink_phase && !cmd_valid && !overrun &&
		&segment_digit_oe_n) else $error("bad values after reset");
endmodule : lds_serial_blink_asserts

// File: verification/lds_host_model.sv
// Host serial master: byte frames; bits8 runs the clock whether select is low or not.
// Assumes the bench calls one task at a time.
`timescale 1ns/100ps

module lds_host_model (
	output logic ser_clk,
	output logic ser_cs_n,
	output logic ser_din
);
	// Idle: select high, clock parked low
	initial begin
		ser_clk = 1'h0;
		ser_cs_n = 1'h1;
		ser_din = 1'h0;
	end
	// MSB first at 15 ns; clock rises in the middle of each bit
	task automatic bits8(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			ser_din = b[i];
			#7.5 ser_clk = 1'h1;
			#7.5 ser_clk = 1'h0;
		end
	endtask : bits8
	task automatic cs_lo();
		#10 ser_cs_n = 1'h0;
		#10;
	endtask : cs_lo
	// Long high gap so the word crosses before new bits shift
	task automatic cs_hi();
		#5 ser_cs_n = 1'h1;
		// Released data flips so no stale level lingers
		ser_din = ~ser_din;
		#200;
	endtask : cs_hi
endmodule : lds_host_model

// File: verification/lds_serial_blink_bench.sv
// Bench: random and corner frames, queue fill, blink timing, pins.
// Assumes core files compiled first; host model drives the link.
`timescale 1ns/100ps
`include "lds_params.svh"

module lds_serial_blink_bench;
	localparam int SH = 20;
	localparam int FH = 10;
	logic clk_sys, rst_n, mux_pin, mux_sel, cmd_ready, ov_clr, hold;
	wire logic ser_clk, ser_cs_n, ser_din;
	wire logic cmd_valid, blink_phase, shutdown, overrun;
	wire logic [7:0] cmd_addr, cmd_data;
	wire logic [8:0] pins, oe_n;
	logic [15:0] exp_q[$];
	logic [15:0] w;
	int err_count, n_checks, n_rx, n;

	lds_host_model host (.ser_clk(ser_clk), .ser_cs_n(ser_cs_n),
		.ser_din(ser_din));
	lds_serial_blink #(.SLOW_HALF_TICKS(SH), .FAST_HALF_TICKS(FH)) dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .ser_clk(ser_clk),
		.ser_cs_n(ser_cs_n), .ser_din(ser_din), .multiplex_clock_pin(mux_pin),
		.mux_ext_sel(mux_sel), .cmd_ready(cmd_ready), .overrun_clr(ov_clr),
		.cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.blink_phase(blink_phase), .shutdown(shutdown), .overrun(overrun),
		.segment_digit_outputs(pins), .segment_digit_oe_n(oe_n));

	// 20 MHz system clock; 2 MHz mux clock offset from its edges
	initial begin
		clk_sys = 1'h0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		mux_pin = 1'h0;
		#13;
		forever #250 mux_pin = ~mux_pin;
	end
	// Consumer: random stalls, words compared in latch order
	always @(negedge clk_sys) cmd_ready <= hold ? 1'h0 : 1'($urandom);
	always @(posedge clk_sys) begin
		if (rst_n && cmd_valid === 1'h1 && cmd_ready) begin
			n_rx++;
			chk({cmd_addr, cmd_data}, exp_q.size() ? exp_q.pop_front() : 'x);
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys);
	endtask : cyc
	task automatic wr(input logic [15:0] v);
		exp_q.push_back(v);
		host.cs_lo();
		host.bits8(v[15:8]);
		host.bits8(v[7:0]);
		host.cs_hi();
	endtask : wr
	// Cycles until the blink phase next flips, bounded
	task automatic gap(output int c);
		logic p;
		p = blink_phase;
		c = 0;
		do begin
			@(posedge clk_sys);
			#1 c++;
		end while (blink_phase === p && c < 3000);
	endtask : gap
	task automatic do_reset(input logic sel);
		rst_n = 1'h0;
		mux_sel = sel;
		cyc(3);
		rst_n = 1'h1;
		cyc(3);
	endtask : do_reset
	task automatic finish_test();
		$display("Checks %0d, errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// Watchdog well past the expected run length
	initial begin
		#2000000;
		err_count++;
		finish_test();
	end

	initial begin
		w = 16'($urandom(12));
		hold = 1'h0;
		ov_clr = 1'h0;
		cmd_ready = 1'h0;
		do_reset(1'h0);
		chk(16'({shutdown, blink_phase, cmd_valid, overrun}), 16'hC);
		chk(16'(oe_n), 16'h01FF);
		repeat (8) begin
			w = 16'($urandom);
			w[15:8] = (w[15:8] == 8'h04) ? 8'h44 : w[15:8];
			wr(w);
		end
		cyc(40);
		// Clocks with select high must not shift; short and long frames
		wr(16'h5AC3);
		host.bits8(8'hFF);
		exp_q.push_back(16'hC396);
		host.cs_lo();
		host.bits8(8'h96);
		host.cs_hi();
		exp_q.push_back(16'h3C0F);
		host.cs_lo();
		host.bits8(8'hE7);
		host.bits8(8'h3C);
		host.bits8(8'h0F);
		host.cs_hi();
		cyc(40);
		// Stall until words are dropped; tail of queue is what was lost
		hold = 1'h1;
		cyc(2);
		n_rx = 0;
		repeat (14) wr(16'($urandom_range(16'h0500, 16'hFFFF)));
		cyc(10);
		chk(16'(overrun), 16'h1);
		// Random clear requests; overrun must hold until one is set
		n = 0;
		do begin
			ov_clr = 1'($urandom);
			cyc(1);
			n++;
			if (!ov_clr) begin
				chk(16'(overrun), 16'h1);
			end
		end while (!ov_clr && n < 16);
		ov_clr = 1'h0;
		cyc(1);
		chk(16'(overrun), 16'h0);
		hold = 1'h0;
		cyc(100);
		chk(16'(n_rx >= 8 && exp_q.size() > 0), 16'h1);
		// Slot, queue, output register and capture slot fill; rest lost
		chk(16'(n_rx), 16'(`LDS_FIFO_DEPTH + 3));
		chk(16'(exp_q.size()), 16'(11 - `LDS_FIFO_DEPTH));
		exp_q.delete();
		// Run with slow blink, then fast, timer restarted each time
		wr(16'h01FF);
		wr(16'h0419);
		cyc(20);
		chk(16'(shutdown), 16'h0);
		// Phase on, all eight segments lit: one sink, seven sources
		chk(16'(oe_n), 16'h0100);
		chk(16'($countones(pins)), 16'h0007);
		gap(n);
		gap(n);
		chk(16'(n), 16'(SH * 5));
		gap(n);
		chk(16'(n), 16'(SH * 5));
		// Phase off: segments released, only the digit sink driven
		cyc(2);
		chk(16'(pins), 16'h0000);
		chk(16'($countones(oe_n)), 16'h0008);
		wr(16'h041D);
		// Let the timing reset land before the gaps are timed
		cyc(20);
		gap(n);
		gap(n);
		chk(16'(n), 16'(FH * 5));
		wr(16'h0400);
		cyc(20);
		chk(16'(oe_n), 16'h01FF);
		// Mid-run reset onto the external mux clock
		do_reset(1'h1);
		wr(16'h041D);
		gap(n);
		gap(n);
		gap(n);
		chk(16'(n), 16'(FH * 10));
		cyc(20);
		finish_test();
	end
endmodule : lds_serial_blink_bench

bind lds_serial_blink lds_serial_blink_asserts u_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .ser_cs_n(ser_cs_n),
	.cmd_ready(cmd_ready), .overrun_clr(overrun_clr),
	.cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
	.blink_phase(blink_phase), .shutdown(shutdown), .overrun(overrun),
	.segment_digit_outputs(segment_digit_outputs),
	.segment_digit_oe_n(segment_digit_oe_n));
